// ### verilog/fcr_pkg.sv
// Purpose: Shared constants and types of the flash configuration registers.
// Assumes: System clock of 10 ns; opcodes are plain defaults.
// Notes:   Field positions follow the 16-bit and 8-bit config words.
package fcr_pkg;

  // Clock and boot timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_FULL_US   = 500;
  localparam int POR_FAST_US   = 100;
  localparam int POR_FULL_CYC  = POR_FULL_US * 1000 / CLK_PERIOD_NS;
  localparam int POR_FAST_CYC  = POR_FAST_US * 1000 / CLK_PERIOD_NS;

  // Instruction opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_READ_STATUS     = 8'h05;
  localparam logic [7:0] OP_WRITE_VOLATILE  = 8'h81;
  localparam logic [7:0] OP_READ_VOLATILE   = 8'h85;
  localparam logic [7:0] OP_WRITE_NONVOL    = 8'hb1;
  localparam logic [7:0] OP_READ_NONVOL     = 8'hb5;

  // Nonvolatile word fields
  localparam int NV_DUMMY_LO = 12;
  localparam int NV_XIP_LO   = 9;
  localparam int NV_DRV_LO   = 6;
  localparam int NV_FAST_POR = 5;
  localparam int NV_HOLD_DIS = 4;
  localparam int NV_QUAD     = 3;
  localparam int NV_DUAL     = 2;

  // Volatile word fields
  localparam int VC_DUMMY_LO = 4;
  localparam int VC_XIP      = 3;

  // Reset values and codes
  localparam logic [15:0] NV_RESET    = 16'hffff;
  localparam logic [7:0]  VC_RESET    = 8'hf8;
  localparam logic [7:0]  VC_RSVD_CLR = 8'hf8;
  localparam logic [3:0]  DUMMY_DFLT  = 4'hf;
  localparam logic [2:0]  XIP_OFF     = 3'h7;
  localparam logic [2:0]  DRV_DFLT    = 3'h7;

  // Status byte bits
  localparam int ST_BUSY  = 0;
  localparam int ST_LATCH = 1;

  // Snapshot word sent to the link side
  localparam int SNAP_W      = 35;
  localparam int SN_NV_LO    = 0;
  localparam int SN_VC_LO    = 16;
  localparam int SN_ST_LO    = 24;
  localparam int SN_PROTO_LO = 32;
  localparam int SN_XIP      = 34;

  typedef enum logic [1:0] {FCR_EXT, FCR_DUAL, FCR_QUAD} fcr_proto_t;

  localparam logic [SNAP_W-1:0] SNAP_RESET = {1'b0, FCR_EXT, 8'h00, VC_RESET, NV_RESET};

  // Data lines used per clock in a protocol
  function automatic logic [3:0] fcr_lanes(input fcr_proto_t p);
    case (p)
      FCR_DUAL: fcr_lanes = 4'h2;
      FCR_QUAD: fcr_lanes = 4'h4;
      default:  fcr_lanes = 4'h1;
    endcase
  endfunction

endpackage

// ### verilog/fcr_link_if.sv
// Purpose: Carrier between the link logic and the register core.
// Assumes: Toggles mark new data; data is stable before a toggle flips.
// Notes:   No clock inside; each side synchronises the other's toggle.
`timescale 1ns/1ps
interface fcr_link_if;
  logic [7:0]                byte_q;
  logic                      byte_tgl;
  logic [fcr_pkg::SNAP_W-1:0] snap;
  logic                      snap_tgl;
  logic                      snap_ack;

  modport link (output byte_q, output byte_tgl, input snap, input snap_tgl, output snap_ack);
  modport core (input byte_q, input byte_tgl, output snap, output snap_tgl, input snap_ack);
endinterface

// ### verilog/fcr_link.sv
// Purpose: Serial link end on the host clock: byte capture and read-out.
// Assumes: Host clock stops between frames; select high ends a frame.
// Notes:   Reads loop over the selected word for as long as clocked.
`timescale 1ns/1ps
module fcr_link (
  // Link pins
  input  wire logic       spi_clk,
  input  wire logic       spi_cs_n,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe,
  // Reset
  input  wire logic       rst_n,
  // Core side
  fcr_link_if.link        lnk
);

  logic [1:0]                 snap_sync_q;
  logic [fcr_pkg::SNAP_W-1:0] shadow_q;
  logic [3:0]                 bit_q;
  logic [1:0]                 idx_q;
  logic [7:0]                 sh_q;
  logic                       rd_en_q;
  logic [15:0]                rd_word_q;
  logic [3:0]                 opos_q;
  fcr_pkg::fcr_proto_t        proto;
  logic [3:0]                 lanes;
  logic [7:0]                 nb;
  logic                       done;

  // Word that a read opcode returns
  function automatic logic [15:0] pick(input logic [7:0] op,
                                       input logic [fcr_pkg::SNAP_W-1:0] s);
    case (op)
      fcr_pkg::OP_READ_STATUS:   pick = {2{s[fcr_pkg::SN_ST_LO +: 8]}};
      fcr_pkg::OP_READ_VOLATILE: pick = {2{s[fcr_pkg::SN_VC_LO +: 8]}};
      fcr_pkg::OP_READ_NONVOL:   pick = s[fcr_pkg::SN_NV_LO +: 16];
      default:                   pick = 16'h0000;
    endcase
  endfunction

  // Captured configuration, two-flop request with acknowledge back
  always_ff @(posedge spi_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      snap_sync_q  <= 2'h0;
      shadow_q     <= fcr_pkg::SNAP_RESET;
      lnk.snap_ack <= 1'b0;
    end
    else
    begin
      snap_sync_q <= {snap_sync_q[0], lnk.snap_tgl};
      // Core holds the word until acknowledged, so no change is lost
      if (snap_sync_q[1] != lnk.snap_ack)
      begin
        shadow_q     <= lnk.snap;
        lnk.snap_ack <= snap_sync_q[1];
      end
    end
  end

  // Lines per clock and the byte being shifted in
  always_comb
  begin
    proto = fcr_pkg::fcr_proto_t'(shadow_q[fcr_pkg::SN_PROTO_LO +: 2]);
    lanes = fcr_pkg::fcr_lanes(proto);
    case (proto)
      fcr_pkg::FCR_DUAL: nb = {sh_q[5:0], io_i[1:0]};
      fcr_pkg::FCR_QUAD: nb = {sh_q[3:0], io_i};
      default:           nb = {sh_q[6:0], io_i[0]};
    endcase
    done = (bit_q + lanes) == 4'h8;
  end

  // Frame state, cleared by the frame's own select
  always_ff @(posedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      bit_q     <= 4'h0;
      idx_q     <= 2'h0;
      sh_q      <= 8'h00;
      rd_en_q   <= 1'b0;
      rd_word_q <= 16'h0000;
    end
    else
    begin
      sh_q  <= nb;
      bit_q <= done ? 4'h0 : bit_q + lanes;
      if (done && idx_q == 2'h0)
      begin
        rd_en_q   <= !shadow_q[fcr_pkg::SN_XIP] && (nb == fcr_pkg::OP_READ_STATUS
                     || nb == fcr_pkg::OP_READ_VOLATILE || nb == fcr_pkg::OP_READ_NONVOL);
        rd_word_q <= pick(nb, shadow_q);
      end
      if (done && idx_q != 2'h3)
        idx_q <= idx_q + 2'h1;
    end
  end

  // Completed bytes handed to the core
  always_ff @(posedge spi_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lnk.byte_q   <= 8'h00;
      lnk.byte_tgl <= 1'b0;
    end
    else if (done)
    begin
      lnk.byte_q   <= nb;
      lnk.byte_tgl <= ~lnk.byte_tgl;
    end
  end

  // Read data driven on the falling edge
  always_ff @(negedge spi_clk or posedge spi_cs_n)
  begin
    if (spi_cs_n)
    begin
      io_o   <= 4'h0;
      io_oe  <= 4'h0;
      opos_q <= 4'h0;
    end
    else if (rd_en_q)
    begin
      opos_q <= opos_q + lanes;
      case (proto)
        fcr_pkg::FCR_DUAL:
        begin
          io_o  <= {2'b00, rd_word_q[4'hf - opos_q], rd_word_q[4'he - opos_q]};
          io_oe <= 4'h3;
        end
        fcr_pkg::FCR_QUAD:
        begin
          io_o  <= rd_word_q[4'hf - opos_q -: 4];
          io_oe <= 4'hf;
        end
        default:
        begin
          io_o  <= {2'b00, rd_word_q[4'hf - opos_q], 1'b0};
          io_oe <= 4'h2;
        end
      endcase
    end
    else
    begin
      io_o  <= 4'h0;
      io_oe <= 4'h0;
    end
  end

endmodule

// ### verilog/fcr_top.sv
// Purpose: Boot and volatile configuration words of a serial flash.
// Assumes: Host clock on spi_clk; rst_n is a cold factory reset.
// Notes:   power_cycle models a power-on; it reloads from the boot word.
//
// Overview of operation
// - Boot word top nibble sets dummy count
// - All-ones dummy code is the safe default
// - Too few dummy cycles give undefined data
// - Boot XiP field starts addresses-only mode
// - Default XiP field boots extended, no XiP
// - Three-bit drive field, default 30 ohm
// - Fast boot allows reads after 100 us
// - First write enable runs second boot phase
// - Default full boot, write enable no latency
// - Boot bit disables hold on line three
// - Quad bit zero boots quad protocol
// - Dual bit zero boots dual protocol
// - Both zero means quad protocol wins
// - Volatile write overrides working settings at once
// - Volatile bits 7..4 set dummy count
// - Volatile bit 3 zero readies XiP
// - Basic-XiP parts ignore volatile bit 3
// - Boot word changes act after power-on
// - Boot word delivered all ones
// - Fast-boot bit zero fast, one full
`timescale 1ns/1ps
module fcr_top #(
  parameter int unsigned FULL_POR_CYC = fcr_pkg::POR_FULL_CYC,
  parameter int unsigned FAST_POR_CYC = fcr_pkg::POR_FAST_CYC,
  parameter bit          BASIC_XIP    = 1'b0
) (
  // System
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       power_cycle,
  // Serial link pins
  input  wire logic       spi_clk,
  input  wire logic       spi_cs_n,
  input  wire logic [3:0] io_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe,
  // Working configuration
  output logic      [3:0] dummy_cycles_q,
  output logic      [2:0] xip_boot_mode_q,
  output logic            xip_ready_q,
  output logic      [2:0] drive_code_q,
  output logic            hold_en_q,
  output logic      [1:0] proto_q,
  // Boot state
  output logic            por_busy_q,
  output logic            read_only_q
);

  localparam int CNT_W = 17;

  // Elaboration checks
  if (FULL_POR_CYC < 1 || FULL_POR_CYC >= (1 << CNT_W))
  begin : g_chk_full
    $error("FULL_POR_CYC out of range");
  end
  if (FAST_POR_CYC < 1 || FAST_POR_CYC >= (1 << CNT_W))
  begin : g_chk_fast
    $error("FAST_POR_CYC out of range");
  end

  typedef enum logic [2:0] {
    PH_BOOT_FULL,
    PH_BOOT_FAST,
    PH_READ_ONLY,
    PH_SECOND,
    PH_READY
  } fcr_phase_t;

  fcr_link_if lnk ();

  fcr_phase_t              phase_q;
  logic [CNT_W-1:0]        cnt_q;
  logic [3:0]              cs_sync_q;
  logic [2:0]              bt_sync_q;
  logic [2:0]              pc_sync_q;
  logic [1:0]              ack_sync_q;
  logic [1:0]              idx_q;
  logic [7:0]              op_q;
  logic [7:0]              d1_q;
  logic [7:0]              d2_q;
  logic [15:0]             nv_q;
  logic [7:0]              vc_q;
  logic                    latch_q;
  logic [fcr_pkg::SNAP_W-1:0] snap_d;
  logic                    byte_evt;
  logic                    frame_end;
  logic                    boot_evt;
  logic                    xip_on;
  logic                    ok_read;
  logic                    do_write_latch_set_cmd;
  logic                    do_wvol;
  logic                    do_wnv;

  // Dummy code to cycle count
  function automatic logic [3:0] dummy_of(input logic [3:0] code);
    dummy_of = (code == 4'h0) ? fcr_pkg::DUMMY_DFLT : code;
  endfunction

  // Protocol chosen by boot bits
  function automatic fcr_pkg::fcr_proto_t proto_of(input logic [15:0] nv);
    if (!nv[fcr_pkg::NV_QUAD])
      proto_of = fcr_pkg::FCR_QUAD;
    else if (!nv[fcr_pkg::NV_DUAL])
      proto_of = fcr_pkg::FCR_DUAL;
    else
      proto_of = fcr_pkg::FCR_EXT;
  endfunction

  // Link end on the host clock
  fcr_link u_link (
    .spi_clk  (spi_clk),
    .spi_cs_n (spi_cs_n),
    .io_i     (io_i),
    .io_o     (io_o),
    .io_oe    (io_oe),
    .rst_n    (rst_n),
    .lnk      (lnk.link)
  );

  // Pin and toggle synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cs_sync_q  <= 4'hf;
      bt_sync_q  <= 3'h0;
      pc_sync_q  <= 3'h0;
      ack_sync_q <= 2'h0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[2:0], spi_cs_n};
      bt_sync_q  <= {bt_sync_q[1:0], lnk.byte_tgl};
      pc_sync_q  <= {pc_sync_q[1:0], power_cycle};
      ack_sync_q <= {ack_sync_q[0], lnk.snap_ack};
    end
  end

  // Events; frame end lags byte events by one cycle
  always_comb
  begin
    byte_evt  = bt_sync_q[2] ^ bt_sync_q[1];
    frame_end = cs_sync_q[2] & ~cs_sync_q[3];
    boot_evt  = pc_sync_q[1] & ~pc_sync_q[2];
    xip_on    = xip_boot_mode_q != fcr_pkg::XIP_OFF;
  end

  // Byte assembly of one instruction
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || frame_end)
    begin
      idx_q <= 2'h0;
      op_q  <= 8'h00;
      d1_q  <= 8'h00;
      d2_q  <= 8'h00;
    end
    else if (byte_evt)
    begin
      case (idx_q)
        2'h0:    op_q <= lnk.byte_q;
        2'h1:    d1_q <= lnk.byte_q;
        2'h2:    d2_q <= lnk.byte_q;
        default: d2_q <= d2_q;
      endcase
      if (idx_q != 2'h3)
        idx_q <= idx_q + 2'h1;
    end
  end

  // Instruction acceptance by boot phase
  always_comb
  begin
    ok_read = (phase_q == PH_READY) || (phase_q == PH_READ_ONLY);
    do_write_latch_set_cmd = frame_end && !xip_on && idx_q != 2'h0
              && op_q == fcr_pkg::OP_WRITE_LATCH_SET && ok_read;
    do_wvol = frame_end && !xip_on && idx_q >= 2'h2
              && op_q == fcr_pkg::OP_WRITE_VOLATILE && phase_q == PH_READY;
    do_wnv  = frame_end && !xip_on && idx_q == 2'h3 && latch_q
              && op_q == fcr_pkg::OP_WRITE_NONVOL && phase_q == PH_READY;
  end

  // Boot phase sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || boot_evt)
    begin
      // boot bit picks fast or full
      if (!rst_n || nv_q[fcr_pkg::NV_FAST_POR])
      begin
        phase_q <= PH_BOOT_FULL;
        cnt_q   <= CNT_W'(FULL_POR_CYC - 1);
      end
      else
      begin
        phase_q <= PH_BOOT_FAST;
        cnt_q   <= CNT_W'(FAST_POR_CYC - 1);
      end
    end
    else
    begin
      case (phase_q)
        PH_BOOT_FULL, PH_SECOND:
        begin
          cnt_q <= cnt_q - CNT_W'(1);
          if (cnt_q == '0)
            phase_q <= PH_READY;
        end
        PH_BOOT_FAST:
        begin
          cnt_q <= cnt_q - CNT_W'(1);
          if (cnt_q == '0)
            phase_q <= PH_READ_ONLY;
        end
        PH_READ_ONLY:
        begin
          if (do_write_latch_set_cmd)
          begin
            phase_q <= PH_SECOND;
            cnt_q   <= CNT_W'(FULL_POR_CYC - 1);
          end
        end
        PH_READY:
          phase_q <= PH_READY;
        default:
          phase_q <= PH_BOOT_FULL;
      endcase
    end
  end

  // Boot state flags
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      por_busy_q  <= 1'b1;
      read_only_q <= 1'b0;
    end
    else
    begin
      por_busy_q  <= phase_q != PH_READY && phase_q != PH_READ_ONLY;
      read_only_q <= phase_q == PH_READ_ONLY;
    end
  end

  // Write latch
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || boot_evt)
      latch_q <= 1'b0;
    else if (do_write_latch_set_cmd)
      latch_q <= 1'b1;
    else if (do_wnv)
      latch_q <= 1'b0;
  end

  // Boot word store
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      nv_q <= fcr_pkg::NV_RESET;
    else if (do_wnv)
      nv_q <= {d1_q, d2_q};
  end

  // Volatile word
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      vc_q <= fcr_pkg::VC_RESET;
    else if (boot_evt)
      vc_q <= {nv_q[fcr_pkg::NV_DUMMY_LO +: 4], 1'b1, 3'h0};
    else if (do_wvol)
      vc_q <= d1_q & fcr_pkg::VC_RSVD_CLR;
  end

  // Working dummy count and XiP readiness
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dummy_cycles_q <= fcr_pkg::DUMMY_DFLT;
      xip_ready_q    <= BASIC_XIP;
    end
    else if (boot_evt)
    begin
      dummy_cycles_q <= dummy_of(nv_q[fcr_pkg::NV_DUMMY_LO +: 4]);
      xip_ready_q    <= BASIC_XIP;
    end
    else if (do_wvol)
    begin
      dummy_cycles_q <= dummy_of(d1_q[fcr_pkg::VC_DUMMY_LO +: 4]);
      xip_ready_q    <= BASIC_XIP || !d1_q[fcr_pkg::VC_XIP];
    end
  end

  // dummy count is advisory to reads
  // Boot-only settings, taken at power-on
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      xip_boot_mode_q <= fcr_pkg::XIP_OFF;
      drive_code_q    <= fcr_pkg::DRV_DFLT;
      hold_en_q       <= 1'b1;
      proto_q         <= fcr_pkg::FCR_EXT;
    end
    else if (boot_evt)
    begin
      xip_boot_mode_q <= nv_q[fcr_pkg::NV_XIP_LO +: 3];
      drive_code_q    <= nv_q[fcr_pkg::NV_DRV_LO +: 3];
      hold_en_q       <= nv_q[fcr_pkg::NV_HOLD_DIS];
      proto_q         <= proto_of(nv_q);
    end
  end

  // Snapshot of readable state for the link
  always_comb
  begin
    snap_d = {xip_on, proto_q, 6'h00, latch_q, por_busy_q, vc_q, nv_q};
  end

  // Publish snapshot with a toggle on change
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      lnk.snap     <= fcr_pkg::SNAP_RESET;
      lnk.snap_tgl <= 1'b0;
    end
    // One word in flight; the next waits for the link's acknowledge
    else if (snap_d != lnk.snap && ack_sync_q[1] == lnk.snap_tgl)
    begin
      lnk.snap     <= snap_d;
      lnk.snap_tgl <= ~lnk.snap_tgl;
    end
  end

endmodule

// ### verif/fcr_host_model.sv
// Purpose: Host end of the serial link, extended protocol frames.
// Assumes: Link clock of 125 ns, parked low between frames.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/1ps
module fcr_host_model (
  // Host driven pins
  output logic            spi_clk,
  output logic            spi_cs_n,
  output logic      [3:0] io_i,
  // Device read data
  input  wire logic [3:0] io_o
);
  // Idle link
  initial
  begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    io_i     = 4'h5;
  end

  // One frame: opcode then nb bytes, MSB first; last 16 bits read back
  task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nb,
                       output logic [15:0] rd);
    logic [23:0] sh;
    sh = {op, wd};
    rd = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 * (nb + 1); i++)
    begin
      io_i[0] = sh[23];
      sh = sh << 1;
      #62.5 spi_clk = 1'b1;
      rd = {rd[14:0], io_o[1]};
      #62.5 spi_clk = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    io_i = ~io_i;
    #100;
  endtask
endmodule

// ### verif/fcr_chk.sv
// Purpose: Port-level assertions of the configuration registers.
// Assumes: Frames start at least 6 system cycles after the last one.
// Notes:   Bound into the top module.
`timescale 1ns/1ps
module fcr_chk #(
  parameter int unsigned FULL_POR_CYC = 50000,
  parameter int unsigned FAST_POR_CYC = 10000,
  parameter bit          BASIC_XIP    = 1'b0
) (
  // System
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       power_cycle,
  // Link
  input wire logic       spi_cs_n,
  input wire logic [3:0] io_oe,
  // Working configuration
  input wire logic [3:0] dummy_cycles_q,
  input wire logic [2:0] xip_boot_mode_q,
  input wire logic       xip_ready_q,
  input wire logic [2:0] drive_code_q,
  input wire logic       hold_en_q,
  input wire logic [1:0] proto_q,
  input wire logic       por_busy_q
);
  logic [31:0] busy_cnt_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Length of the running boot phase
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !por_busy_q)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end

  a_dummy_never_zero: assert property (dummy_cycles_q != 4'h0)
    else $error("dummy count shows zero");
  a_cold_defaults: assert property ($rose(rst_n) |-> dummy_cycles_q == 4'hf
    && xip_boot_mode_q == 3'h7 && drive_code_q == 3'h7 && hold_en_q && proto_q == 2'h0
    && por_busy_q && xip_ready_q == BASIC_XIP)
    else $error("reset values wrong");
  a_boot_bounded: assert property (por_busy_q |-> busy_cnt_q <= FULL_POR_CYC + 4)
    else $error("boot phase too long");
  a_boot_min_len: assert property ($fell(por_busy_q) |-> busy_cnt_q + 1 >= FAST_POR_CYC)
    else $error("boot phase too short");
  a_power_reload: assert property ($rose(power_cycle) |-> ##[1:8] por_busy_q)
    else $error("power-on did not start boot");
  a_lane_match: assert property (io_oe != 4'h0 |-> io_oe ==
    (proto_q == 2'h2 ? 4'hf : (proto_q == 2'h1 ? 4'h3 : 4'h2)))
    else $error("drive lanes do not fit protocol");
  a_cfg_frame_stable: assert property (!spi_cs_n [*8] |-> $stable(dummy_cycles_q))
    else $error("config moved inside a frame");
  a_proto_legal: assert property (proto_q != 2'h3)
    else $error("protocol code illegal");

  c_quad: cover property (proto_q == 2'h2);
  c_xip_ready: cover property ($rose(xip_ready_q));
  c_fast_boot: cover property ($fell(por_busy_q) && busy_cnt_q < FULL_POR_CYC / 2);
endmodule

bind fcr_top fcr_chk #(.FULL_POR_CYC(FULL_POR_CYC), .FAST_POR_CYC(FAST_POR_CYC),
  .BASIC_XIP(BASIC_XIP)) fcr_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .power_cycle(power_cycle), .spi_cs_n(spi_cs_n), .io_oe(io_oe),
  .dummy_cycles_q(dummy_cycles_q), .xip_boot_mode_q(xip_boot_mode_q),
  .xip_ready_q(xip_ready_q), .drive_code_q(drive_code_q), .hold_en_q(hold_en_q),
  .proto_q(proto_q), .por_busy_q(por_busy_q));

// ### verif/fcr_tb_top.sv
// Purpose: Self-checking bench of the configuration registers.
// Assumes: Host frames in extended protocol only.
// Notes:   Short boot counts keep the run brief.
`timescale 1ns/1ps
module fcr_tb_top;
  localparam int unsigned FULL_CYC = 400;
  localparam int unsigned FAST_CYC = 8;

  logic        sys_clk;
  logic        rst_n;
  logic        power_cycle;
  logic        spi_clk;
  logic        spi_cs_n;
  logic [3:0]  io_i;
  logic [3:0]  io_o;
  logic [3:0]  io_oe;
  logic [3:0]  dummy_cycles_q;
  logic [2:0]  xip_boot_mode_q;
  logic        xip_ready_q;
  logic [2:0]  drive_code_q;
  logic        hold_en_q;
  logic [1:0]  proto_q;
  logic        por_busy_q;
  logic        read_only_q;
  logic [15:0] rd;
  logic [15:0] nv;
  logic [7:0]  vc;
  logic [3:0]  ed;
  logic [1:0]  ep;
  int          errors;
  int          checked;
  logic [7:0]  vc_tab [4] = '{8'h00, 8'h18, 8'ha8, 8'hf8};
  logic [15:0] nv_tab [3] = '{16'h5eeb, 16'h0ff3, 16'ha877};

  // Compare, count, report
  `define FCR_CHECK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %s expected %0h seen %0h", nm, (exp), (got)); \
    end \
  end

  // System clock
  always #5 sys_clk = ~sys_clk;

  fcr_top #(.FULL_POR_CYC(FULL_CYC), .FAST_POR_CYC(FAST_CYC), .BASIC_XIP(1'b0)) fcr_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .power_cycle(power_cycle), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe),
    .dummy_cycles_q(dummy_cycles_q), .xip_boot_mode_q(xip_boot_mode_q),
    .xip_ready_q(xip_ready_q), .drive_code_q(drive_code_q), .hold_en_q(hold_en_q),
    .proto_q(proto_q), .por_busy_q(por_busy_q), .read_only_q(read_only_q));

  fcr_host_model fcr_host_model_inst (
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .io_i(io_i), .io_o(io_o));

  // One host frame
  task automatic xfer(input logic [7:0] op, input logic [15:0] wd, input int nb);
    fcr_host_model_inst.frame(op, wd, nb, rd);
  endtask

  // Wait for boot end; check its length when len is set
  task automatic wait_boot(input int len);
    int n;
    n = 0;
    while (por_busy_q !== 1'b0 && n < 5000)
    begin
      @(negedge sys_clk);
      n++;
    end
    `FCR_CHECK("boot_done", 1'b0, por_busy_q)
    if (len > 0)
      `FCR_CHECK("boot_len", 1'b1, (n + 8 >= len) && (n <= len + 8))
  endtask

  // Cold reset for 12 cycles, then full boot
  task automatic cold_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_boot(FULL_CYC);
  endtask

  // Power-on pulse, reload from boot word
  task automatic power_on(input int len);
    @(posedge sys_clk);
    power_cycle <= 1'b1;
    // Outlast sync and phase latency so the boot is already busy
    repeat (8) @(posedge sys_clk);
    power_cycle <= 1'b0;
    wait_boot(len);
  endtask

  // Working configuration against expected fields
  task automatic cfg_check(input logic [3:0] d, input logic [2:0] x, input logic [2:0] dr,
                           input logic h, input logic [1:0] p);
    `FCR_CHECK("dummy", d, dummy_cycles_q)
    `FCR_CHECK("xip_boot", x, xip_boot_mode_q)
    `FCR_CHECK("drive", dr, drive_code_q)
    `FCR_CHECK("hold_en", h, hold_en_q)
    `FCR_CHECK("proto", p, proto_q)
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Test sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    power_cycle = 1'b0;
    errors = 0;
    checked = 0;
    cold_reset();
    cfg_check(4'hf, 3'h7, 3'h7, 1'b1, 2'h0);
    `FCR_CHECK("xip_ready", 1'b0, xip_ready_q)
    xfer(fcr_pkg::OP_READ_NONVOL, 16'h0, 2);
    `FCR_CHECK("boot_word", 16'hffff, rd)
    $display("test defaults done");
    for (int i = 0; i < 4; i++)
    begin
      vc = vc_tab[i];
      ed = (vc[7:4] == 4'h0) ? 4'hf : vc[7:4];
      xfer(fcr_pkg::OP_WRITE_VOLATILE, {vc, 8'h00}, 1);
      `FCR_CHECK("vol_dummy", ed, dummy_cycles_q)
      `FCR_CHECK("xip_ready", ~vc[3], xip_ready_q)
      xfer(fcr_pkg::OP_READ_VOLATILE, 16'h0, 1);
      `FCR_CHECK("vol_word", vc, rd[7:0])
    end
    $display("test volatile done");
    for (int i = 0; i < 3; i++)
    begin
      nv = nv_tab[i];
      ed = (nv[15:12] == 4'h0) ? 4'hf : nv[15:12];
      ep = !nv[3] ? 2'h2 : (!nv[2] ? 2'h1 : 2'h0);
      cold_reset();
      xfer(fcr_pkg::OP_WRITE_LATCH_SET, 16'h0, 0);
      `FCR_CHECK("latch_no_wait", 1'b0, por_busy_q)
      xfer(fcr_pkg::OP_WRITE_NONVOL, nv, 2);
      `FCR_CHECK("before_power", 4'hf, dummy_cycles_q)
      power_on(FULL_CYC);
      cfg_check(ed, nv[11:9], nv[8:6], nv[4], ep);
    end
    $display("test boot words done");
    cold_reset();
    xfer(fcr_pkg::OP_WRITE_LATCH_SET, 16'h0, 0);
    xfer(fcr_pkg::OP_WRITE_NONVOL, 16'hffdf, 2);
    power_on(FAST_CYC);
    `FCR_CHECK("read_only", 1'b1, read_only_q)
    xfer(fcr_pkg::OP_READ_VOLATILE, 16'h0, 1);
    `FCR_CHECK("fast_read", 8'hf8, rd[7:0])
    xfer(fcr_pkg::OP_WRITE_LATCH_SET, 16'h0, 0);
    `FCR_CHECK("second_phase", 1'b1, por_busy_q)
    xfer(fcr_pkg::OP_WRITE_VOLATILE, 16'h1000, 1);
    xfer(fcr_pkg::OP_READ_STATUS, 16'h0, 1);
    `FCR_CHECK("status", 8'h03, rd[7:0])
    wait_boot(0);
    `FCR_CHECK("refused_write", 4'hf, dummy_cycles_q)
    `FCR_CHECK("read_only_end", 1'b0, read_only_q)
    $display("test fast boot done");
    results();
  end

  // Watchdog well above the expected run
  initial
  begin
    #800000;
    errors++;
    results();
  end
endmodule
